// >>> design/ihw_ctrl.sv
// System control: interrupt, halt and wake-up, upper register bank over APB
//
// Behaviour
// R1: Interrupt jumps to 0x008, reset to 0x000, wake-up to 0x004.
// R2: Sample interrupt flag rises at 32768 Hz, or 65536 Hz with double rate.
// R3: Enable set and flag set: interrupt accepted on the next clock.
// R4: Acceptance saves pc, page high, bank, carry, zero and jumps in one clock.
// R5: Entering service clears the global interrupt enable.
// R6: Entry leaves the sample flag set; software clears it.
// R7: Return from service restores context and sets the enable; subroutine return does not.
// R8: One service level only; acceptance needs the enable set.
// R9: Halt stops the core clock and program counter; memory kept.
// R10: Rising edge on any port A pin wakes from halt.
// R11: Halt sets pc to 0x004; wake waits 64 clocks before advancing.
// R12: Reset beats wake-up: pc goes to 0x000, advance after 64 clocks.
// R13: Mode change attempts are ignored while halted.
// R14: High sample nibble gives bits 7-4, 9-6 or 11-8; top bit is sign.
// R15: Gain select 00..11 gives gain 50,100,150,200 when gain enabled.
// R16: Trim field gives -4,-2,+2,+4 percent when trim option enabled.
// R17: Gain enable switches record gain; format bit selects two's complement.
// R18: Speaker wake sets sticky flag software clears; two-bit sensitivity field.
// R19: Low supply register: enable bit 0, read-only detect flag bit 1.
// R20: Four-bit threshold code picks detect level 2.1 V to 3.8 V.
// R21: Four nibble registers form a 16-bit data ROM address, lowest first.
// R22: Data registers read ROM nibbles; high data write kicks watchdog.
// R23: Low sample nibble gives bits 3-0, 5-2 or 7-4 by resolution.
// R24: Reserved addresses ignore writes and read undefined (zero here).
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "ihw_params.svh"
module ihw_ctrl
    import ihw_pkg::*;
#(
    parameter int RATE_DIV      = `IHW_RATE_DIV,
    parameter int RATE_FAST_DIV = `IHW_RATE_FAST_DIV,
    parameter int STABLE_CLKS   = `IHW_STABLE_CLKS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        double_rate_option,
    input  wire logic        ten_bit_option,
    input  wire logic        twelve_bit_option,
    input  wire logic        trim_enable_option,
    input  wire logic        watchdog_option,
    input  wire logic [3:0]  port_a_pins,
    input  wire logic        speaker_event,
    input  wire logic        low_supply_sense,
    input  wire logic [7:0]  rom_data,
    input  wire logic        halt_exec,
    input  wire logic        return_from_service,
    input  wire logic        return_from_subroutine,
    input  wire ihw_ctx_t    core_ctx,
    output ihw_ctx_t         restore_ctx,
    output logic             restore_load,
    output logic             pc_load,
    output logic      [11:0] pc_target,
    output logic             core_clk_enable,
    output logic             irq_taken,
    output logic      [11:0] pwm_sample,
    output logic             sample_negative,
    output logic             audio_output_enable,
    output logic      [1:0]  gain_select,
    output logic             record_gain_enable,
    output logic      [1:0]  freq_trim,
    output logic             freq_trim_active,
    output logic             twos_complement_select,
    output logic      [1:0]  speaker_wake_sensitivity,
    output logic             low_supply_enable,
    output logic      [3:0]  low_supply_level,
    output logic      [15:0] rom_addr,
    output logic             watchdog_kick
);
    logic [3:0]  scratch2;
    logic        sample_irq_flag;
    logic        global_irq_enable;
    logic        irq_pending;
    logic        speaker_wake_flag;
    logic        speaker_wake_enable;
    logic        low_supply_flag;
    logic [3:0]  gain_trim;
    logic [3:0]  fmt;
    ihw_sample_t sample;
    logic [3:0]  rom_a [4];
    logic [3:0]  port_a_prev;
    logic [6:0]  settle_cnt;
    logic [15:0] rate_cnt;
    logic [15:0] rate_limit;
    logic        rate_tick;
    logic        wake_event;
    logic        spk_wake;
    ihw_mode_t   mode;
    ihw_ctx_t    shadow;

    logic        bus_wr;
    logic        bus_rd;
    logic [4:0]  addr;
    logic [3:0]  wnib;
    logic [31:0] next_prdata;

    assign addr   = paddr[6:2];
    assign wnib   = pwdata[3:0];
    assign bus_wr = psel && penable && pwrite && !pready && (paddr[31:7] == 25'h0);
    assign bus_rd = psel && penable && !pwrite && !pready;

    // One wait state: answer in the cycle after access phase starts
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
        end
    end

    always_comb begin
        next_prdata = 32'h0;
        if (paddr[31:7] == 25'h0) begin
            unique case (addr)
                `IHW_OFF_STATUS:    next_prdata[3:0] = {1'b0, sample_irq_flag,
                                                        core_ctx.carry, core_ctx.zero};
                `IHW_OFF_IRQCTL:    next_prdata[3:0] = {2'b00, global_irq_enable,
                                                        audio_output_enable};
                `IHW_OFF_SCRATCH2:  next_prdata[3:0] = scratch2;
                `IHW_OFF_GAIN_TRIM: next_prdata[3:0] = gain_trim;
                `IHW_OFF_FORMAT:    next_prdata[3:0] = fmt;
                `IHW_OFF_SPK_WAKE:  next_prdata[3:0] = {speaker_wake_flag,
                                        speaker_wake_sensitivity, speaker_wake_enable};
                `IHW_OFF_LOW_SUP:   next_prdata[3:0] = {2'b00, low_supply_flag,
                                                        low_supply_enable}; // R19
                `IHW_OFF_LOW_LEVEL: next_prdata[3:0] = low_supply_level;
                `IHW_OFF_ROM_A0:    next_prdata[3:0] = rom_a[0];
                `IHW_OFF_ROM_A1:    next_prdata[3:0] = rom_a[1];
                `IHW_OFF_ROM_A2:    next_prdata[3:0] = rom_a[2];
                `IHW_OFF_ROM_A3:    next_prdata[3:0] = rom_a[3];
                `IHW_OFF_ROM_DL:    next_prdata[3:0] = rom_data[3:0]; // R22
                `IHW_OFF_ROM_DH:    next_prdata[3:0] = rom_data[7:4]; // R22
                `IHW_OFF_CORE_STAT: next_prdata[3:0] = {1'b0, mode};
                default:            next_prdata = 32'h0; // R24
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (bus_rd) begin
            prdata <= next_prdata;
        end
    end

    // Plain bus registers; reserved offsets fall through untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            scratch2                 <= `IHW_RST_NIBBLE;
            gain_trim                <= `IHW_RST_NIBBLE;
            fmt                      <= `IHW_RST_NIBBLE;
            speaker_wake_enable      <= 1'b0;
            speaker_wake_sensitivity <= 2'b00;
            low_supply_enable        <= 1'b0;
            low_supply_level         <= `IHW_RST_NIBBLE;
            audio_output_enable      <= 1'b0;
            sample                   <= '0;
            for (int i = 0; i < 4; i++) begin
                rom_a[i] <= `IHW_RST_NIBBLE;
            end
        end else if (bus_wr) begin
            unique case (addr)
                `IHW_OFF_SCRATCH2:   scratch2 <= wnib;
                `IHW_OFF_GAIN_TRIM:  gain_trim <= wnib; // R15 R16
                `IHW_OFF_FORMAT:     fmt <= {wnib[3], 1'b0, wnib[1], 1'b0}; // R17
                `IHW_OFF_SPK_WAKE: begin
                    speaker_wake_enable      <= wnib[`IHW_BIT_SPK_EN];
                    speaker_wake_sensitivity <= wnib[2:1]; // R18
                end
                `IHW_OFF_LOW_SUP:    low_supply_enable <= wnib[`IHW_BIT_LOW_EN]; // R19
                `IHW_OFF_LOW_LEVEL:  low_supply_level <= wnib; // R20
                `IHW_OFF_IRQCTL:     audio_output_enable <= wnib[`IHW_BIT_AUDIO_EN];
                `IHW_OFF_SAMPLE_HI:  sample.high <= wnib; // R14
                `IHW_OFF_SAMPLE_LOW: sample.mid <= wnib; // R23
                `IHW_OFF_SAMPLE_EXT: sample.low <= wnib; // R23
                `IHW_OFF_ROM_A0:     rom_a[0] <= wnib; // R21
                `IHW_OFF_ROM_A1:     rom_a[1] <= wnib; // R21
                `IHW_OFF_ROM_A2:     rom_a[2] <= wnib; // R21
                `IHW_OFF_ROM_A3:     rom_a[3] <= wnib; // R21
                default:             ; // R24
            endcase
        end
    end

    // Configuration fields driven out
    always_ff @(posedge clk) begin
        if (rst) begin
            gain_select            <= 2'b00;
            freq_trim              <= 2'b00;
            freq_trim_active       <= 1'b0;
            record_gain_enable     <= 1'b0;
            twos_complement_select <= 1'b0;
            rom_addr               <= 16'h0;
            pwm_sample             <= 12'h0;
            sample_negative        <= 1'b0;
            low_supply_flag        <= 1'b0;
        end else begin
            gain_select            <= gain_trim[3:2]; // R15
            freq_trim              <= gain_trim[1:0]; // R16
            freq_trim_active       <= trim_enable_option; // R16
            record_gain_enable     <= fmt[3]; // R17
            twos_complement_select <= fmt[1]; // R17
            rom_addr               <= {rom_a[3], rom_a[2], rom_a[1], rom_a[0]}; // R21
            sample_negative        <= sample.high[3]; // R14
            low_supply_flag        <= low_supply_enable && low_supply_sense; // R19
            if (twelve_bit_option) begin
                pwm_sample <= {sample.high, sample.mid, sample.low}; // R14 R23
            end else if (ten_bit_option) begin
                pwm_sample <= {2'b00, sample.high, sample.mid, sample.low[3:2]}; // R23
            end else begin
                pwm_sample <= {4'h0, sample.high, sample.mid}; // R14 R23
            end
        end
    end

    // Watchdog kick on any write to the high data register
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_kick <= 1'b0;
        end else begin
            watchdog_kick <= bus_wr && (addr == `IHW_OFF_ROM_DH) && watchdog_option; // R22
        end
    end

    // Sample-rate tick
    assign rate_limit = double_rate_option ? 16'(RATE_FAST_DIV - 1)
                                           : 16'(RATE_DIV - 1);
    assign rate_tick  = (rate_cnt >= rate_limit);

    always_ff @(posedge clk) begin
        if (rst) begin
            rate_cnt <= 16'h0;
        end else if (rate_tick) begin
            rate_cnt <= 16'h0; // R2
        end else begin
            rate_cnt <= rate_cnt + 16'h1;
        end
    end

    // Sample flag: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_irq_flag <= 1'b0;
        end else if (rate_tick && audio_output_enable) begin
            sample_irq_flag <= 1'b1; // R2
        end else if (bus_wr && addr == `IHW_OFF_STATUS) begin
            sample_irq_flag <= wnib[`IHW_BIT_SAMPLE_FLAG]; // R6
        end
    end

    // Speaker wake flag: sticky, set wins
    assign spk_wake = speaker_wake_enable && speaker_event && mode == IHW_HALT;

    always_ff @(posedge clk) begin
        if (rst) begin
            speaker_wake_flag <= 1'b0;
        end else if (spk_wake) begin
            speaker_wake_flag <= 1'b1; // R18
        end else if (bus_wr && addr == `IHW_OFF_SPK_WAKE && !wnib[`IHW_BIT_SPK_FLAG]) begin
            speaker_wake_flag <= 1'b0; // R18
        end
    end

    // Interrupt acceptance and return
    assign irq_pending = global_irq_enable && sample_irq_flag && mode == IHW_RUN; // R3 R8

    always_ff @(posedge clk) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
            irq_taken         <= 1'b0;
            shadow            <= '0;
            restore_load      <= 1'b0;
            restore_ctx       <= '0;
        end else begin
            irq_taken    <= irq_pending; // R3
            restore_load <= 1'b0;
            if (irq_pending) begin
                shadow            <= core_ctx; // R4
                global_irq_enable <= 1'b0; // R5
            end else if (return_from_service && mode == IHW_RUN) begin
                restore_ctx       <= shadow; // R7
                restore_load      <= 1'b1; // R7
                global_irq_enable <= 1'b1; // R7
            end else if (bus_wr && addr == `IHW_OFF_IRQCTL) begin
                global_irq_enable <= wnib[`IHW_BIT_GIE];
            end
        end
    end

    // Halt, wake and settle
    assign wake_event = (|(port_a_pins & ~port_a_prev)) || spk_wake; // R10

    always_ff @(posedge clk) begin
        if (rst) begin
            port_a_prev <= 4'h0;
        end else begin
            port_a_prev <= port_a_pins;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode            <= IHW_SETTLE; // R12
            settle_cnt      <= 7'h0;
            pc_load         <= 1'b1;
            pc_target       <= `IHW_VEC_RESET; // R1 R12
            core_clk_enable <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            unique case (mode)
                IHW_RUN: begin
                    if (irq_pending) begin
                        pc_load   <= 1'b1;
                        pc_target <= `IHW_VEC_IRQ; // R1 R4
                    end else if (halt_exec) begin
                        mode            <= IHW_HALT; // R9
                        core_clk_enable <= 1'b0; // R9
                        pc_load         <= 1'b1;
                        pc_target       <= `IHW_VEC_WAKE; // R11
                    end
                end
                IHW_HALT: begin
                    if (wake_event) begin // R13
                        mode       <= IHW_SETTLE; // R10
                        settle_cnt <= 7'h0;
                    end
                end
                IHW_SETTLE: begin
                    settle_cnt <= settle_cnt + 7'h1;
                    if (settle_cnt == 7'(STABLE_CLKS - 1)) begin
                        mode            <= IHW_RUN; // R11 R12
                        core_clk_enable <= 1'b1;
                    end
                end
                default: mode <= IHW_RUN;
            endcase
        end
    end

    a_irq_entry_vec: assert property (@(posedge clk) disable iff (rst)
        irq_pending |=> pc_load && pc_target == `IHW_VEC_IRQ && !global_irq_enable)
        else $error("interrupt entry wrong"); // R1
    a_irq_context: assert property (@(posedge clk) disable iff (rst)
        irq_pending |=> shadow == $past(core_ctx))
        else $error("context not saved"); // R4
    a_flag_kept: assert property (@(posedge clk) disable iff (rst)
        irq_pending && !(bus_wr && addr == `IHW_OFF_STATUS) |=> sample_irq_flag)
        else $error("flag cleared on entry"); // R6
    a_return_gie: assert property (@(posedge clk) disable iff (rst)
        return_from_service && mode == IHW_RUN && !irq_pending
        |=> global_irq_enable && restore_load)
        else $error("return did not restore"); // R7
    a_no_nest: assert property (@(posedge clk) disable iff (rst)
        !global_irq_enable |=> !irq_taken)
        else $error("accepted while disabled"); // R8
    a_halt_vec: assert property (@(posedge clk) disable iff (rst)
        mode == IHW_RUN && halt_exec && !irq_pending
        |=> mode == IHW_HALT && pc_target == `IHW_VEC_WAKE && !core_clk_enable)
        else $error("halt entry wrong"); // R11
    a_settle_len: assert property (@(posedge clk) disable iff (rst)
        mode == IHW_HALT && wake_event |=> !core_clk_enable [*8] ##[56:60] core_clk_enable)
        else $error("settle length wrong"); // R11
    a_halt_hold: assert property (@(posedge clk) disable iff (rst)
        mode == IHW_HALT && !wake_event |=> mode == IHW_HALT)
        else $error("left halt without wake"); // R13
    a_spk_sticky: assert property (@(posedge clk) disable iff (rst)
        spk_wake |=> speaker_wake_flag)
        else $error("speaker flag not set"); // R18
    a_wd_kick: assert property (@(posedge clk) disable iff (rst)
        bus_wr && addr == `IHW_OFF_ROM_DH && watchdog_option |=> watchdog_kick)
        else $error("watchdog not kicked"); // R22
endmodule : ihw_ctrl

// >>> inc/ihw_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IHW_PARAMS_SVH
`define IHW_PARAMS_SVH
`define IHW_OFF_STATUS      5'h00
`define IHW_OFF_IRQCTL      5'h09
`define IHW_OFF_SAMPLE_LOW  5'h0A
`define IHW_OFF_SAMPLE_HI   5'h0B
`define IHW_OFF_SCRATCH2    5'h0F
`define IHW_OFF_GAIN_TRIM   5'h10
`define IHW_OFF_FORMAT      5'h11
`define IHW_OFF_SPK_WAKE    5'h12
`define IHW_OFF_LOW_SUP     5'h13
`define IHW_OFF_LOW_LEVEL   5'h14
`define IHW_OFF_ROM_A0      5'h18
`define IHW_OFF_ROM_A1      5'h19
`define IHW_OFF_ROM_A2      5'h1A
`define IHW_OFF_ROM_A3      5'h1B
`define IHW_OFF_ROM_DL      5'h1C
`define IHW_OFF_ROM_DH      5'h1D
`define IHW_OFF_SAMPLE_EXT  5'h08
`define IHW_OFF_CORE_STAT   5'h1F
`define IHW_BIT_SAMPLE_FLAG 2
`define IHW_BIT_CARRY       1
`define IHW_BIT_ZERO        0
`define IHW_BIT_GIE         1
`define IHW_BIT_AUDIO_EN    0
`define IHW_BIT_SPK_FLAG    3
`define IHW_BIT_SPK_EN      0
`define IHW_BIT_LOW_FLAG    1
`define IHW_BIT_LOW_EN      0
`define IHW_VEC_RESET       12'h000
`define IHW_VEC_WAKE        12'h004
`define IHW_VEC_IRQ         12'h008
`define IHW_RST_NIBBLE      4'h0
`define IHW_STABLE_CLKS     64
`define IHW_CLK_HZ          25000000
`define IHW_RATE_HZ         32768
`define IHW_RATE_FAST_HZ    65536
`define IHW_RATE_DIV        (`IHW_CLK_HZ / `IHW_RATE_HZ)
`define IHW_RATE_FAST_DIV   (`IHW_CLK_HZ / `IHW_RATE_FAST_HZ)
`endif

// >>> inc/ihw_pkg.sv
// Types shared by the system control block
package ihw_pkg;
    typedef enum logic [2:0] {
        IHW_RUN    = 3'b001,
        IHW_HALT   = 3'b010,
        IHW_SETTLE = 3'b100
    } ihw_mode_t;

    typedef struct packed {
        logic [11:0] pc;
        logic [3:0]  page_high;
        logic        bank;
        logic        carry;
        logic        zero;
    } ihw_ctx_t;

    typedef struct packed {
        logic [3:0] high;
        logic [3:0] mid;
        logic [3:0] low;
    } ihw_sample_t;
endpackage : ihw_pkg

// >>> verif/ihw_core_model.sv
// Behavioural model of the processor core that faces the control block
`timescale 1ns/1ps
module ihw_core_model
    import ihw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  cmd,
    input  wire logic        pc_load,
    input  wire logic [11:0] pc_target,
    input  wire logic        restore_load,
    input  wire ihw_ctx_t    restore_ctx,
    input  wire logic        core_clk_enable,
    output ihw_ctx_t         core_ctx,
    output logic             halt_exec,
    output logic             return_from_service,
    output logic             return_from_subroutine
);
    // Context steps only while the core clock runs, so a stall is visible
    always_ff @(posedge clk) begin
        if (rst) begin
            core_ctx <= '{12'h000, 4'h5, 1'b1, 1'b0, 1'b1};
        end else if (restore_load) begin
            core_ctx <= restore_ctx;
        end else if (pc_load) begin
            core_ctx.pc <= pc_target;
        end else if (core_clk_enable) begin
            core_ctx.pc        <= core_ctx.pc + 12'h001;
            core_ctx.page_high <= core_ctx.page_high + 4'h1;
            core_ctx.carry     <= ~core_ctx.carry;
        end
    end
    // Instruction strobes last one cycle
    always_ff @(posedge clk) begin
        halt_exec              <= ~rst & (cmd == 2'd1);
        return_from_service    <= ~rst & (cmd == 2'd2);
        return_from_subroutine <= ~rst & (cmd == 2'd3);
    end
endmodule : ihw_core_model

// >>> verif/irq_halt_wakeup_sfr_ctrl_test.sv
// Bench: register access, interrupt entry and return, halt and wake-up
`timescale 1ns/1ps
module irq_halt_wakeup_sfr_ctrl_test;
    import ihw_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pins = 4'h0;
    logic        spk = 1'b0;
    logic        sense = 1'b0;
    logic        b10 = 1'b0, b12 = 1'b0, perr, aoe, lse;
    logic [1:0]  cmd = 2'd0;
    logic [31:0] prdata;
    logic        pready, pc_load, cclk, irq_taken, restore_load, kick, sneg, rge, twos, trim_on;
    logic        hx, rs, rsub;
    logic [11:0] pc_target, pwm_sample;
    logic [1:0]  gsel, trim, sens;
    logic [3:0]  lvl, rd;
    logic [15:0] rom_addr;
    ihw_ctx_t    cctx, rctx;
    int          fails = 0, samples_checked = 0, waited, kicks = 0, irqs = 0, restores = 0;
    logic [11:0] held;
    logic [4:0]  zero_regs [5] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

    always #20 clk = ~clk;

    ihw_ctrl #(.RATE_DIV(8), .RATE_FAST_DIV(4), .STABLE_CLKS(64)) uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
        .double_rate_option(1'b0), .ten_bit_option(b10), .twelve_bit_option(b12),
        .trim_enable_option(1'b1), .watchdog_option(1'b1), .port_a_pins(pins),
        .speaker_event(spk), .low_supply_sense(sense), .rom_data(rom_addr[7:0] + 8'h11),
        .halt_exec(hx), .return_from_service(rs), .return_from_subroutine(rsub),
        .core_ctx(cctx), .restore_ctx(rctx), .restore_load(restore_load),
        .pc_load(pc_load), .pc_target(pc_target), .core_clk_enable(cclk),
        .irq_taken(irq_taken), .pwm_sample(pwm_sample), .sample_negative(sneg),
        .audio_output_enable(aoe), .gain_select(gsel), .record_gain_enable(rge),
        .freq_trim(trim), .freq_trim_active(trim_on), .twos_complement_select(twos),
        .speaker_wake_sensitivity(sens), .low_supply_enable(lse), .low_supply_level(lvl),
        .rom_addr(rom_addr), .watchdog_kick(kick));

    ihw_core_model core (
        .clk(clk), .rst(rst), .cmd(cmd), .pc_load(pc_load), .pc_target(pc_target),
        .restore_load(restore_load), .restore_ctx(rctx), .core_clk_enable(cclk),
        .core_ctx(cctx), .halt_exec(hx), .return_from_service(rs),
        .return_from_subroutine(rsub));

    always @(posedge clk) begin
        kicks    <= kicks + int'(kick === 1'b1);
        irqs     <= irqs + int'(irq_taken === 1'b1);
        restores <= restores + int'(restore_load === 1'b1);
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Counts edges until the watched flag is sampled high
    task automatic wait_hi(ref logic s, input string nm);
        waited = 0;
        do begin
            @(posedge clk);
            waited++;
        end while (s !== 1'b1 && waited < 300);
        if (s !== 1'b1) begin
            chk(nm, 1, 0);
            print_verdict();
        end
    endtask : wait_hi

    task automatic apb(input logic wr, input logic [4:0] idx, input logic [3:0] wd);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {25'h0, idx, 2'b00};
        pwdata <= {28'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        wait_hi(pready, "pready");
        rd = prdata[3:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [4:0] idx, input logic [3:0] e);
        apb(1'b0, idx, 4'h0);
        chk($sformatf("reg %0h", idx), {28'h0, e}, {28'h0, rd});
        chk("pslverr", 32'h0, {31'h0, perr});
    endtask : rdc

    task automatic core_cmd(input logic [1:0] c, input int gap);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'd0;
        repeat (gap) @(posedge clk);
    endtask : core_cmd

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_hi(cclk, "settle");
        chk("reset settle", 1, waited inside {[64:66]});
        foreach (zero_regs[i]) rdc(zero_regs[i], 4'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 5'h10, {i[1:0], ~i[1:0]});
            rdc(5'h10, {i[1:0], ~i[1:0]});
            chk("gain", i, gsel);
            chk("trim", 3 - i, trim);
        end
        chk("trim on", 1, trim_on);
        apb(1'b1, 5'h11, 4'hA);
        rdc(5'h11, 4'hA);
        chk("format", 2'b11, {rge, twos});
        apb(1'b1, 5'h14, 4'h9);
        rdc(5'h14, 4'h9);
        chk("level", 4'h9, lvl);
        sense <= 1'b1;
        apb(1'b1, 5'h13, 4'h3);
        rdc(5'h13, 4'h3);
        chk("supply en", 1, lse);
        sense <= 1'b0;
        rdc(5'h13, 4'h1);
        apb(1'b1, 5'h0F, 4'h6);
        apb(1'b1, 5'h0C, 4'h5);
        rdc(5'h0F, 4'h6);
        rdc(5'h0C, 4'h0);
        apb(1'b1, 5'h0A, 4'h5);
        apb(1'b1, 5'h0B, 4'hC);
        rdc(5'h0B, 4'h0);
        chk("sample", 8'hC5, pwm_sample[7:0]);
        chk("sign", 1, sneg);
        apb(1'b1, 5'h08, 4'h9);
        apb(1'b1, 5'h1E, 4'h3);
        b12 <= 1'b1;
        rdc(5'h08, 4'h0);
        chk("12 bit", 12'hC59, pwm_sample);
        b12 <= 1'b0;
        b10 <= 1'b1;
        apb(1'b0, 5'h0F, 4'h0);
        chk("10 bit", 12'h316, pwm_sample);
        b10 <= 1'b0;
        for (int i = 0; i < 4; i++) apb(1'b1, 5'(24 + i), 4'(i + 1));
        rdc(5'h1C, 4'h2);
        chk("rom addr", 16'h4321, rom_addr);
        rdc(5'h1D, 4'h3);
        apb(1'b1, 5'h1D, 4'h0);
        apb(1'b0, 5'h0F, 4'h0);
        chk("kicks", 1, kicks);
        apb(1'b1, 5'h09, 4'h3);
        wait_hi(irq_taken, "irq");
        chk("irq entry", 13'h1008, {pc_load, pc_target});
        rdc(5'h09, 4'h1);
        chk("audio en", 1, aoe);
        apb(1'b0, 5'h00, 4'h0);
        chk("flag kept", 1, rd[2]);
        repeat (30) @(posedge clk);
        chk("no nesting", 1, irqs);
        core_cmd(2'd3, 2);
        rdc(5'h09, 4'h1);
        apb(1'b1, 5'h09, 4'h0);
        apb(1'b1, 5'h00, 4'h0);
        core_cmd(2'd2, 3);
        chk("restores", 1, restores);
        rdc(5'h09, 4'h2);
        apb(1'b1, 5'h09, 4'h0);
        core_cmd(2'd1, 3);
        chk("halt", 13'h0004, {cclk, pc_target});
        held = cctx.pc;
        core_cmd(2'd1, 10);
        chk("pc held", held, cctx.pc);
        rdc(5'h1F, 4'h2);
        pins <= 4'h4;
        wait_hi(cclk, "wake");
        chk("wake wait", 1, waited inside {[62:66]});
        rdc(5'h1F, 4'h1);
        apb(1'b1, 5'h12, 4'h5);
        apb(1'b0, 5'h0F, 4'h0);
        chk("sensitivity", 2'b10, sens);
        core_cmd(2'd1, 3);
        spk <= 1'b1;
        wait_hi(cclk, "speaker");
        spk <= 1'b0;
        rdc(5'h12, 4'hD);
        apb(1'b1, 5'h12, 4'h5);
        rdc(5'h12, 4'h5);
        core_cmd(2'd1, 3);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset in halt", 13'h1000, {pc_load, pc_target});
        wait_hi(cclk, "reset wake");
        chk("reset wait", 1, waited inside {[62:66]});
        print_verdict();
    end
endmodule : irq_halt_wakeup_sfr_ctrl_test
